// File: rtl/rbb_core.sv
// Broadcast recognition, busy status flag and busy-time transfer control of a
// 1553 remote terminal. Assumes the protocol engine hands over each valid command
// word as a one-cycle strobe and reads back decisions when DECIDE_VLD_O pulses.
// The shared RAM answers a read one cycle after its strobe.
// Notes on behaviour
// - Broadcast-off flag 0: address 31 commands are broadcast.
// - Broadcast-off flag 1: address 31 is an ordinary terminal address.
// - Allow pin at 0 also disables broadcast recognition.
// - Broadcast receive followed directly by own-address transmit: drop broadcast, answer transmit.
// - Host busy bit held low sets busy in every status word while host-driven flags are off.
// - Host-driven flags on: busy follows configuration register one bit 4.
// - Host-driven flags off if extended mode off or their enable bit 0.
// - Busy without suppression active: received data words still stored.
// - Busy, extended, suppression set: non-mode receive data not stored.
// - Busy non-mode transmit: status with busy, no data words.
// - Table busy only in extended mode, host flags off, table enable 1.
// - Table is eight words at 0x0240 plus broadcast, T/R, subaddress MSB.
// - Address bit2 broadcast, bit1 transmit, bit0 subaddress MSB.
// - Subaddress bits 3..0 pick table bit; 1 means busy.
// - Busy vector-word command: omit word unless extended and bypass set.
// - Busy sync-with-data: store unless extended with suppression set and bypass clear.
// - Extended with bypass: vector sent and sync data stored while busy.
// - Busy self-test-word: withheld only if extended and inhibit bit set.
`timescale 1ns/1ps
module rbb_core
  import rbb_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic [2:0]  REG_ADDR_I,
  input  wire logic [15:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [15:0] REG_RDATA_O,
  input  wire logic        BCAST_ALLOW_PIN_I,
  input  wire logic [4:0]  OWN_ADDR_I,
  input  wire logic        CMD_VLD_I,
  input  wire logic [15:0] CMD_WORD_I,
  output logic             RAM_RD_O,
  output logic      [15:0] RAM_ADDR_O,
  input  wire logic [15:0] RAM_RDATA_I,
  output logic             DECIDE_VLD_O,
  output logic             ACCEPT_O,
  output logic             IS_BCAST_O,
  output logic             BUSY_O,
  output logic             STORE_DATA_O,
  output logic             SEND_DATA_O
);

  logic [15:0] cfg1_q;
  logic [15:0] cfg2_q;
  logic [15:0] cfg3_q;
  logic [15:0] cfg4_q;
  logic [15:0] cfg5_q;
  logic        pin_meta_q;
  logic        pin_sync_q;
  logic        bcast_en;
  rbb_state_t  state_q;
  logic [15:0] cmd_q;
  logic        bcast_q;
  logic        pend_bcast_q;
  logic [15:0] pend_cmd_q;
  logic        dec_vld_q;
  logic        accept_q;
  logic        isb_q;
  logic        busy_q;
  logic        store_q;
  logic        send_q;
  logic        last_busy_q;
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  // Configuration registers, one per concern; writes to other indices are ignored
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cfg1_q <= CFG1_RST;
    end else if (REG_WR_I && REG_ADDR_I == REG_CFG1) begin
      cfg1_q <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cfg2_q <= CFG_RST;
    end else if (REG_WR_I && REG_ADDR_I == REG_CFG2) begin
      cfg2_q <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cfg3_q <= CFG_RST;
    end else if (REG_WR_I && REG_ADDR_I == REG_CFG3) begin
      cfg3_q <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cfg4_q <= CFG_RST;
    end else if (REG_WR_I && REG_ADDR_I == REG_CFG4) begin
      cfg4_q <= REG_WDATA_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cfg5_q <= CFG_RST;
    end else if (REG_WR_I && REG_ADDR_I == REG_CFG5) begin
      cfg5_q <= REG_WDATA_I;
    end
  end

  // Read mux; a cycle without read strobe returns zero, so an answer stands one cycle
  always_comb begin
    rdata_d = 16'h0000;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        REG_CFG1:   rdata_d = cfg1_q;
        REG_CFG2:   rdata_d = cfg2_q;
        REG_CFG3:   rdata_d = cfg3_q;
        REG_CFG4:   rdata_d = cfg4_q;
        REG_CFG5:   rdata_d = cfg5_q;
        REG_STATUS: rdata_d = {13'h0000, pend_bcast_q, last_busy_q, bcast_en};
        default:    rdata_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      rdata_q <= 16'h0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign REG_RDATA_O = rdata_q;

  // Allow pin synchroniser; only the second stage is read by logic
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      pin_meta_q <= 1'b1;
    end else begin
      pin_meta_q <= BCAST_ALLOW_PIN_I;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      pin_sync_q <= 1'b1;
    end else begin
      pin_sync_q <= pin_meta_q;
    end
  end

  // Configuration decode
  logic ext_mode;
  logic host_driven_status_flags;
  logic rx_suppress;
  logic mode_cmd_bypass_occupied;
  logic tbl_en;
  logic inh_selftest;
  assign bcast_en = !cfg5_q[CFG5_BCAST_OFF_BIT] && pin_sync_q;
  assign ext_mode = cfg3_q[CFG3_EXT_MODE_BIT];
  assign host_driven_status_flags = ext_mode && cfg3_q[CFG3_HOST_FLAGS_BIT];
  assign rx_suppress = ext_mode && cfg3_q[CFG3_RX_SUPPRESS_BIT];
  assign mode_cmd_bypass_occupied = ext_mode && cfg3_q[CFG3_MODE_BYPASS_BIT];
  assign tbl_en = ext_mode && !host_driven_status_flags
                  && cfg2_q[CFG2_BUSY_TBL_EN_BIT];
  assign inh_selftest = ext_mode && cfg4_q[CFG4_INH_SELFTEST_BIT];

  function automatic logic is_bcast(input logic [15:0] w, input logic en);
    is_bcast = en && (w[15:11] == BCAST_ADDR);
  endfunction : is_bcast

  logic in_bcast;
  logic in_own;
  logic in_tx;
  assign in_bcast = is_bcast(CMD_WORD_I, bcast_en);
  assign in_own   = (CMD_WORD_I[15:11] == OWN_ADDR_I) && !in_bcast;
  assign in_tx    = CMD_WORD_I[10];

  // Sequencer: hold a broadcast receive one command so a following transmit can supersede it
  logic start;
  logic [15:0] start_cmd;
  logic start_bcast;
  always_comb begin
    start = 1'b0;
    start_cmd = CMD_WORD_I;
    start_bcast = 1'b0;
    if (CMD_VLD_I && in_own) begin
      start = 1'b1;
    end else if (CMD_VLD_I && in_bcast && in_tx) begin
      start = 1'b1;
      start_bcast = 1'b1;
    end else if (CMD_VLD_I && !in_bcast && pend_bcast_q) begin
      start = 1'b1;
      start_cmd = pend_cmd_q;
      start_bcast = 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      pend_bcast_q <= 1'b0;
      pend_cmd_q   <= 16'h0000;
    end else if (CMD_VLD_I) begin
      pend_bcast_q <= in_bcast && !in_tx;
      pend_cmd_q   <= CMD_WORD_I;
    end else if (pend_bcast_q && state_q == ST_IDLE) begin
      pend_bcast_q <= 1'b0;
    end
  end

  logic pend_go;
  assign pend_go = !CMD_VLD_I && pend_bcast_q && state_q == ST_IDLE;

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (start || pend_go) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: state_q <= ST_WAIT;
        ST_WAIT:  state_q <= ST_DONE;
        ST_DONE:  state_q <= ST_IDLE;
      endcase
    end
  end

  // Command under work, captured as the sequencer leaves idle
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      cmd_q <= 16'h0000;
    end else if (state_q == ST_IDLE && start) begin
      cmd_q <= start_cmd;
    end else if (state_q == ST_IDLE && pend_go) begin
      cmd_q <= pend_cmd_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      bcast_q <= 1'b0;
    end else if (state_q == ST_IDLE && start) begin
      bcast_q <= start_bcast;
    end else if (state_q == ST_IDLE && pend_go) begin
      bcast_q <= 1'b1;
    end
  end

  // Table read
  assign RAM_RD_O   = (state_q == ST_FETCH) && tbl_en;
  assign RAM_ADDR_O = BUSY_TBL_BASE | {13'h0000, bcast_q, cmd_q[10], cmd_q[9]};

  // Decision: one-hot select of the table bit from the low subaddress bits
  logic [15:0] sa_sel;
  for (genvar g = 0; g < 16; g++) begin : g_sa_sel
    assign sa_sel[g] = (cmd_q[8:5] == 4'(g));
  end

  logic tbl_busy_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      tbl_busy_q <= 1'b0;
    end else if (state_q == ST_WAIT) begin
      tbl_busy_q <= tbl_en && |(RAM_RDATA_I & sa_sel);
    end
  end

  logic busy_c;
  logic mode_c;
  logic tx_c;
  logic [4:0] mc_c;
  always_comb begin
    if (host_driven_status_flags) begin
      busy_c = cfg1_q[CFG1_STATUS_SRC_BIT];
    end else begin
      busy_c = !cfg1_q[CFG1_BUSY_N_BIT] || tbl_busy_q;
    end
  end
  assign mode_c = (cmd_q[9:5] == MC_SA_A) || (cmd_q[9:5] == MC_SA_B);
  assign tx_c   = cmd_q[10];
  assign mc_c   = cmd_q[4:0];

  logic store_c;
  logic send_c;
  always_comb begin
    store_c = !tx_c;
    send_c  = tx_c;
    if (busy_c) begin
      if (!mode_c) begin
        store_c = !tx_c && !rx_suppress;
        send_c  = 1'b0;
      end else if (mc_c == MC_SYNC_DATA) begin
        store_c = !rx_suppress || mode_cmd_bypass_occupied;
        send_c  = 1'b0;
      end else if (mc_c == MC_TX_VECTOR) begin
        send_c  = mode_cmd_bypass_occupied;
        store_c = 1'b0;
      end else if (mc_c == MC_TX_SELFTEST) begin
        send_c  = !inh_selftest;
        store_c = 1'b0;
      end
    end
  end

  // Decision outputs; each except the one-cycle DECIDE_VLD_O strobe holds until the next decision
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      dec_vld_q <= 1'b0;
    end else begin
      dec_vld_q <= (state_q == ST_DONE);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      accept_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      accept_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      isb_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      isb_q <= bcast_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      busy_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      busy_q <= busy_c;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      store_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      store_q <= store_c;
    end
  end

  // A broadcast never answers with data
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      send_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      send_q <= send_c && !bcast_q;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      last_busy_q <= 1'b0;
    end else if (state_q == ST_DONE) begin
      last_busy_q <= busy_c;
    end
  end

  assign DECIDE_VLD_O = dec_vld_q;
  assign ACCEPT_O     = accept_q;
  assign IS_BCAST_O   = isb_q;
  assign BUSY_O       = busy_q;
  assign STORE_DATA_O = store_q;
  assign SEND_DATA_O  = send_q;

endmodule : rbb_core

// File: include/rbb_pkg.sv
// Package for the broadcast/busy status block of a 1553 remote terminal.
// Assumes a 16-bit shared RAM word size and the standard command word layout.
package rbb_pkg;

  // Configuration register field positions
  localparam int CFG1_BUSY_N_BIT      = 15;
  localparam int CFG1_STATUS_SRC_BIT  = 4;
  localparam int CFG2_BUSY_TBL_EN_BIT = 13;
  localparam int CFG3_EXT_MODE_BIT    = 15;
  localparam int CFG3_MODE_BYPASS_BIT = 13;
  localparam int CFG3_HOST_FLAGS_BIT  = 5;
  localparam int CFG3_RX_SUPPRESS_BIT = 3;
  localparam int CFG4_INH_SELFTEST_BIT = 14;
  localparam int CFG5_BCAST_OFF_BIT   = 7;

  // Register indices on the plain register port
  localparam logic [2:0] REG_CFG1   = 3'h0;
  localparam logic [2:0] REG_CFG2   = 3'h1;
  localparam logic [2:0] REG_CFG3   = 3'h2;
  localparam logic [2:0] REG_CFG4   = 3'h3;
  localparam logic [2:0] REG_CFG5   = 3'h4;
  localparam logic [2:0] REG_STATUS = 3'h5;

  // Reset values
  localparam logic [15:0] CFG1_RST  = 16'h8000;
  localparam logic [15:0] CFG_RST   = 16'h0000;

  // Busy lookup table base (upper bits fixed, low three bits formed)
  localparam logic [15:0] BUSY_TBL_BASE = 16'h0240;

  // Command word fields
  localparam logic [4:0] BCAST_ADDR     = 5'h1f;
  localparam logic [4:0] MC_SA_A        = 5'h00;
  localparam logic [4:0] MC_SA_B        = 5'h1f;
  localparam logic [4:0] MC_SYNC_DATA   = 5'h11;
  localparam logic [4:0] MC_TX_VECTOR   = 5'h10;
  localparam logic [4:0] MC_TX_SELFTEST = 5'h13;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_FETCH = 2'b01,
    ST_WAIT  = 2'b10,
    ST_DONE  = 2'b11
  } rbb_state_t;

endpackage : rbb_pkg

// File: verif/rbb_ram_model.sv
// Shared RAM model holding the busy table; answers a read one cycle later.
// Assumes reads are strobed by the core; idle cycles show toggling data.
`timescale 1ns/1ps
module rbb_ram_model (
  input  wire logic        clk_i,
  input  wire logic        rd_i,
  input  wire logic [15:0] addr_i,
  output logic      [15:0] rdata_o = 16'ha5a5
);
  // Word n of the table marks subaddress bit n+2 busy
  always @(posedge clk_i) begin
    if (rd_i && addr_i[15:3] == 13'h0048) rdata_o <= 16'h0004 << addr_i[2:0];
    else rdata_o <= ~rdata_o;
  end
endmodule : rbb_ram_model

// File: verif/rbb_core_chk.sv
// Assertions on the decision, table fetch and register ports of rbb_core.
// Assumes one clock domain and the register map of rbb_pkg.
`timescale 1ns/1ps
module rbb_core_chk
  import rbb_pkg::*;
(
  input wire logic        CLK_SYS_I,
  input wire logic        RSTN_I,
  input wire logic [2:0]  REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic        REG_WR_I,
  input wire logic        REG_RD_I,
  input wire logic [15:0] REG_RDATA_O,
  input wire logic [4:0]  OWN_ADDR_I,
  input wire logic        CMD_VLD_I,
  input wire logic [15:0] CMD_WORD_I,
  input wire logic        RAM_RD_O,
  input wire logic [15:0] RAM_ADDR_O,
  input wire logic        DECIDE_VLD_O,
  input wire logic        ACCEPT_O,
  input wire logic        IS_BCAST_O,
  input wire logic        BUSY_O,
  input wire logic        SEND_DATA_O
);
  logic busy_n_q;
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) busy_n_q <= 1'b1;
    else if (REG_WR_I && REG_ADDR_I == REG_CFG1) busy_n_q <= REG_WDATA_I[CFG1_BUSY_N_BIT];
  end
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (!RSTN_I);
  sequence own_s;
    CMD_VLD_I && CMD_WORD_I[15:11] == OWN_ADDR_I && OWN_ADDR_I != BCAST_ADDR;
  endsequence
  sequence tx_busy_s;
    own_s ##0 (CMD_WORD_I[10] && CMD_WORD_I[9:5] != MC_SA_A && CMD_WORD_I[9:5] != MC_SA_B)
      ##4 (DECIDE_VLD_O && BUSY_O);
  endsequence
  sequence super_s;
    CMD_VLD_I && CMD_WORD_I[15:11] == BCAST_ADDR && !CMD_WORD_I[10]
      ##1 own_s ##0 CMD_WORD_I[10] ##4 DECIDE_VLD_O;
  endsequence
  ram_base_a: assert property (RAM_RD_O |-> RAM_ADDR_O[15:3] == 13'h0048)
    else $error("busy table address outside its base");
  tbl_index_a: assert property (own_s ##1 RAM_RD_O |->
    RAM_ADDR_O[2:0] == {1'b0, $past(CMD_WORD_I[10]), $past(CMD_WORD_I[9])})
    else $error("busy table index wrong");
  fetch_order_a: assert property (RAM_RD_O |-> ##3 DECIDE_VLD_O)
    else $error("decision not three cycles after table fetch");
  decide_pulse_a: assert property (DECIDE_VLD_O |=> !DECIDE_VLD_O)
    else $error("decision strobe longer than one cycle");
  rdata_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
    else $error("read data outside read answer cycle");
  host_busy_a: assert property (DECIDE_VLD_O && !busy_n_q |-> BUSY_O)
    else $error("busy missing while host holds busy");
  tx_nodata_a: assert property (tx_busy_s |-> !SEND_DATA_O)
    else $error("data sent for busy transmit");
  bcast_super_a: assert property (super_s |-> ACCEPT_O && !IS_BCAST_O)
    else $error("broadcast not superseded by own transmit");
endmodule : rbb_core_chk
bind rbb_core rbb_core_chk i_chk (.*);

// File: verif/rbb_core_tb.sv
// Self-checking bench for rbb_core: registers, broadcast and busy decisions.
// Assumes a 10 MHz clock and the busy table held in rbb_ram_model.
`timescale 1ns/1ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t mismatch", $time); end end
module rbb_core_tb;
  import rbb_pkg::*;
  localparam int K_BUSY = 0, K_ST = 1, K_SD = 2, K_BC = 3;
  logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, pin = 1'b1, cvld = 1'b0;
  logic [2:0]  raddr = 3'h0;
  logic [15:0] wdata = 16'h0000, cw = 16'h0000, rdata, ram_addr, ram_rdata;
  logic [4:0]  own = 5'h05;
  logic        ram_rd, dv, acc, bc, busy, st, sd;
  int          mismatches = 0, tests_run = 0;
  rbb_core i_dut (.CLK_SYS_I(clk), .RSTN_I(rstn), .REG_ADDR_I(raddr), .REG_WDATA_I(wdata),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .BCAST_ALLOW_PIN_I(pin),
    .OWN_ADDR_I(own), .CMD_VLD_I(cvld), .CMD_WORD_I(cw), .RAM_RD_O(ram_rd),
    .RAM_ADDR_O(ram_addr), .RAM_RDATA_I(ram_rdata), .DECIDE_VLD_O(dv), .ACCEPT_O(acc),
    .IS_BCAST_O(bc), .BUSY_O(busy), .STORE_DATA_O(st), .SEND_DATA_O(sd));
  rbb_ram_model i_ram (.clk_i(clk), .rd_i(ram_rd), .addr_i(ram_addr), .rdata_o(ram_rdata));
  initial forever #50 clk = ~clk;
  task automatic finish_test;
    $display("mismatches %0d tests_run %0d", mismatches, tests_run);
    if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  function automatic logic [15:0] cwd(logic [4:0] a, logic t, logic [4:0] s, logic [4:0] c);
    return {a, t, s, c};
  endfunction : cwd
  task automatic wreg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    raddr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wreg
  task automatic rreg(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    raddr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask : rreg
  // Second word, when nonzero, follows the first with no gap
  task automatic send(input logic [15:0] w, input logic [15:0] w2);
    int i;
    @(posedge clk);
    cvld <= 1'b1;
    cw <= w;
    @(posedge clk);
    cvld <= (w2 != 16'h0000);
    cw <= w2;
    @(posedge clk);
    cvld <= 1'b0;
    #1;
    for (i = 0; i < 8 && dv !== 1'b1; i++) @(posedge clk) #1;
    if (dv !== 1'b1) begin
      mismatches++;
      $display("ERROR %0t no decision", $time);
      finish_test();
    end
    repeat (2) @(posedge clk);
  endtask : send
  task automatic run(input logic [15:0] w, input int k, input logic e);
    logic [3:0] o;
    send(w, 16'h0000);
    o = {bc, sd, st, busy};
    `CHK(o[k], e)
  endtask : run
  task automatic t_regs;
    rreg(REG_CFG1, CFG1_RST);
    rreg(REG_CFG4, CFG_RST);
    rreg(3'h6, 16'h0000);
    wreg(REG_CFG2, 16'h2000);
    rreg(REG_CFG2, 16'h2000);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_bcast;
    run(cwd(BCAST_ADDR, 1'b0, 5'h01, 5'h02), K_BC, 1'b1);
    wreg(REG_CFG5, 16'h0080);
    own <= BCAST_ADDR;
    run(cwd(BCAST_ADDR, 1'b0, 5'h01, 5'h02), K_BC, 1'b0);
    `CHK(acc, 1'b1)
    wreg(REG_CFG5, 16'h0000);
    pin <= 1'b0;
    repeat (3) @(posedge clk);
    run(cwd(BCAST_ADDR, 1'b0, 5'h01, 5'h02), K_BC, 1'b0);
    pin <= 1'b1;
    own <= 5'h05;
    repeat (3) @(posedge clk);
    send(cwd(BCAST_ADDR, 1'b0, 5'h01, 5'h02), cwd(5'h05, 1'b1, 5'h01, 5'h02));
    `CHK({acc, bc}, 2'b10)
    $display("t_bcast done");
  endtask : t_bcast
  task automatic t_busy;
    wreg(REG_CFG1, 16'h0000);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_BUSY, 1'b1);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_ST, 1'b1);
    run(cwd(5'h05, 1'b0, 5'h00, MC_SYNC_DATA), K_ST, 1'b1);
    run(cwd(5'h05, 1'b1, 5'h1f, MC_TX_VECTOR), K_SD, 1'b0);
    wreg(REG_CFG3, 16'h8008);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_ST, 1'b0);
    run(cwd(5'h05, 1'b1, 5'h01, 5'h04), K_SD, 1'b0);
    run(cwd(5'h05, 1'b1, 5'h00, MC_TX_VECTOR), K_SD, 1'b0);
    run(cwd(5'h05, 1'b1, 5'h00, MC_TX_SELFTEST), K_SD, 1'b1);
    wreg(REG_CFG4, 16'h4000);
    run(cwd(5'h05, 1'b1, 5'h00, MC_TX_SELFTEST), K_SD, 1'b0);
    wreg(REG_CFG3, 16'ha008);
    run(cwd(5'h05, 1'b1, 5'h00, MC_TX_VECTOR), K_SD, 1'b1);
    run(cwd(5'h05, 1'b0, 5'h1f, MC_SYNC_DATA), K_ST, 1'b1);
    $display("t_busy done");
  endtask : t_busy
  task automatic t_host;
    wreg(REG_CFG1, 16'h8010);
    wreg(REG_CFG3, 16'h8020);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_BUSY, 1'b1);
    wreg(REG_CFG1, 16'h8000);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_BUSY, 1'b0);
    wreg(REG_CFG1, 16'h8010);
    wreg(REG_CFG3, 16'h0020);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_BUSY, 1'b0);
    wreg(REG_CFG3, 16'h8000);
    run(cwd(5'h05, 1'b0, 5'h01, 5'h04), K_BUSY, 1'b0);
    $display("t_host done");
  endtask : t_host
  task automatic t_table;
    wreg(REG_CFG1, 16'h8000);
    run(cwd(5'h05, 1'b0, 5'h02, 5'h01), K_BUSY, 1'b1);
    run(cwd(5'h05, 1'b0, 5'h03, 5'h01), K_BUSY, 1'b0);
    run(cwd(5'h05, 1'b0, 5'h13, 5'h01), K_BUSY, 1'b1);
    run(cwd(5'h05, 1'b0, 5'h12, 5'h01), K_BUSY, 1'b0);
    run(cwd(5'h05, 1'b1, 5'h04, 5'h01), K_BUSY, 1'b1);
    run(cwd(5'h05, 1'b1, 5'h02, 5'h01), K_BUSY, 1'b0);
    run(cwd(BCAST_ADDR, 1'b0, 5'h06, 5'h01), K_BUSY, 1'b1);
    wreg(REG_CFG3, 16'h8020);
    run(cwd(5'h05, 1'b0, 5'h02, 5'h01), K_BUSY, 1'b0);
    wreg(REG_CFG3, 16'h8000);
    wreg(REG_CFG2, 16'h0000);
    run(cwd(5'h05, 1'b0, 5'h02, 5'h01), K_BUSY, 1'b0);
    $display("t_table done");
  endtask : t_table
  initial begin
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_bcast();
    t_busy();
    t_host();
    t_table();
    finish_test();
  end
endmodule : rbb_core_tb
